// >>> pkg/dblc_pkg.sv
// constants and types for the double-buffered converter latch driver
// assumes a 125 MHz system clock and a latch device on plain pins
package dblc_pkg;

    localparam int DBLC_DATA_W = 16;
    localparam int DBLC_FIFO_DEPTH = 8;
    localparam int DBLC_CLK_PERIOD_NS = 8;

    // timing figures in ns, then cycle counts (least times round up)
    localparam int DBLC_STROBE_LOW_NS = 160;
    localparam int DBLC_STROBE_HIGH_NS = 80;
    localparam int DBLC_DATA_HOLD_NS = 16;
    localparam int DBLC_DESKEW_NS = 100;
    localparam int DBLC_SETTLE_NS = 13000;
    localparam int DBLC_STROBE_LOW_CYC =
        (DBLC_STROBE_LOW_NS + DBLC_CLK_PERIOD_NS - 1) / DBLC_CLK_PERIOD_NS;
    localparam int DBLC_STROBE_HIGH_CYC =
        (DBLC_STROBE_HIGH_NS + DBLC_CLK_PERIOD_NS - 1) / DBLC_CLK_PERIOD_NS;
    localparam int DBLC_DATA_HOLD_CYC =
        (DBLC_DATA_HOLD_NS + DBLC_CLK_PERIOD_NS - 1) / DBLC_CLK_PERIOD_NS;
    localparam int DBLC_DESKEW_CYC =
        (DBLC_DESKEW_NS + DBLC_CLK_PERIOD_NS - 1) / DBLC_CLK_PERIOD_NS;
    localparam int DBLC_SETTLE_CYC =
        (DBLC_SETTLE_NS + DBLC_CLK_PERIOD_NS - 1) / DBLC_CLK_PERIOD_NS;

    localparam logic [15:0] DBLC_TOP_BIT_MASK = 16'h8000;
    localparam logic [15:0] DBLC_CNT_ONE = 16'h0001;
    localparam logic [15:0] DBLC_CNT_ZERO = 16'h0000;

    // mode codes for the wiring style used on the board
    localparam logic DBLC_MODE_DOUBLE = 1'b0;
    localparam logic DBLC_MODE_EDGE = 1'b1;

    // one sample request: word plus flags
    typedef struct packed {
        logic [DBLC_DATA_W-1:0] word;
        logic twos_comp;
        logic update;
    } dblc_req_t;

    // pin group toward the converter latches
    typedef struct packed {
        logic [DBLC_DATA_W-1:0] data;
        logic select_n;
        logic load_n;
        logic update;
    } dblc_pins_t;

    typedef enum logic [5:0] {
        DBLC_IDLE = 6'h01,
        DBLC_LOAD = 6'h02,
        DBLC_HOLD = 6'h04,
        DBLC_GAP = 6'h08,
        DBLC_UPD = 6'h10,
        DBLC_SETL = 6'h20
    } dblc_state_t;

endpackage

// >>> logic/dblc_fifo.sv
// small synchronous fifo of parameterised width and depth
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/10ps
module dblc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign in_ready_o = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    ////////////////////////////////////////////////////////////////////
    // storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers wrap at the depth
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0
                              : wr_ptr_reg + AW'(1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0
                              : rd_ptr_reg + AW'(1);
            end
        end
    end

    // occupancy
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + (AW+1)'(1);
        end else if (pop && !push) begin
            count_reg <= count_reg - (AW+1)'(1);
        end
    end
endmodule

// >>> logic/dblc_host.sv
// host driver for a double-buffered converter latch device
// assumes the device pins are driven straight from these outputs;
// the device itself has no clock and no reset
`timescale 1ns/10ps
module dblc_host
    import dblc_pkg::*;
#(
    parameter int DATA_W = DBLC_DATA_W,
    parameter int FIFO_DEPTH = DBLC_FIFO_DEPTH,
    parameter int SETTLE_CYC = DBLC_SETTLE_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [DATA_W-1:0] SAMPLE_I,
    input wire logic SAMPLE_TWOS_I,
    input wire logic SAMPLE_UPDATE_I,
    input wire logic SAMPLE_VALID_I,
    output logic SAMPLE_READY_O,
    input wire logic EDGE_MODE_I,
    input wire logic UPDATE_ALL_I,
    output logic [DATA_W-1:0] DATA_O,
    output logic SELECT_N_O,
    output logic LOAD_N_O,
    output logic UPDATE_O,
    output logic BUSY_O,
    output logic LOADED_O
);

    localparam int RW = DATA_W + 2;
    localparam int SW = (SETTLE_CYC > 65535) ? 32 : 16;
    localparam int OW = $clog2(FIFO_DEPTH) + 1;
    // joined pair stays high at least the strobe high time, even when
    // the settling wait is configured shorter than that
    localparam int EDGE_SETL_CYC = (SETTLE_CYC > DBLC_STROBE_HIGH_CYC)
        ? SETTLE_CYC : DBLC_STROBE_HIGH_CYC;

    logic [RW-1:0] fifo_out;
    logic fifo_valid;
    logic fifo_pop;
    logic accept;
    dblc_req_t req;
    dblc_state_t state_reg;
    dblc_state_t state_next;
    logic [SW-1:0] cnt_reg;
    logic [SW-1:0] cnt_next;
    logic mode_reg;
    logic upd_pend_reg;
    logic upd_req_reg;
    logic [DATA_W-1:0] data_reg;
    logic select_n_reg;
    logic load_n_reg;
    logic update_reg;
    logic loaded_reg;
    logic ready_reg;
    logic mode_meta_reg;
    logic mode_sync_reg;
    logic all_meta_reg;
    logic all_sync_reg;
    logic all_prev_reg;
    logic [OW-1:0] occ_reg;
    logic [OW-1:0] occ_next;
    logic busy_reg;
    logic mode_chg;

    // twos-complement samples get the top bit flipped to offset binary
    function automatic logic [DATA_W-1:0] dblc_code(
        input logic [DATA_W-1:0] w, input logic tc);
        dblc_code = tc ? (w ^ DATA_W'(DBLC_TOP_BIT_MASK)) : w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // sample buffer; back-pressure reaches the source
    dblc_fifo #(
        .WIDTH(RW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .in_data_i({SAMPLE_I, SAMPLE_TWOS_I, SAMPLE_UPDATE_I}),
        .in_valid_i(accept),
        .in_ready_o(),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop)
    );

    assign req = dblc_req_t'(fifo_out);
    // no word leaves the buffer while a wiring change is being settled
    assign mode_chg = (mode_sync_reg != mode_reg);
    assign fifo_pop = (state_reg == DBLC_IDLE) && fifo_valid && !mode_chg;
    assign accept = SAMPLE_VALID_I && ready_reg;

    // words held in the buffer, mirrored so source ready is a flop
    always_comb begin
        occ_next = occ_reg;
        if (accept && !fifo_pop) begin
            occ_next = occ_reg + OW'(DBLC_CNT_ONE);
        end else if (fifo_pop && !accept) begin
            occ_next = occ_reg - OW'(DBLC_CNT_ONE);
        end
    end

    // occupancy mirror; follows the buffer's own count cycle for cycle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            occ_reg <= '0;
        end else begin
            occ_reg <= occ_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // synchronisers for the two level inputs from outside the domain
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_meta_reg <= 1'b0;
            mode_sync_reg <= 1'b0;
            all_meta_reg <= 1'b0;
            all_sync_reg <= 1'b0;
            all_prev_reg <= 1'b0;
        end else begin
            mode_meta_reg <= EDGE_MODE_I;
            mode_sync_reg <= mode_meta_reg;
            all_meta_reg <= UPDATE_ALL_I;
            all_sync_reg <= all_meta_reg;
            all_prev_reg <= all_sync_reg;
        end
    end

    // rising edge of the broadcast update request, held until served
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            upd_req_reg <= 1'b0;
        end else if (all_sync_reg && !all_prev_reg) begin
            upd_req_reg <= 1'b1; // set wins over clear
        end else if (state_reg == DBLC_UPD
                     || mode_reg == DBLC_MODE_EDGE) begin
            upd_req_reg <= 1'b0; // edge wiring drops broadcast requests
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg == '0) ? '0 : cnt_reg - SW'(DBLC_CNT_ONE);
        case (state_reg)
            DBLC_IDLE: begin
                if (mode_chg) begin
                    // let the pins rest in the new wiring before use
                    state_next = DBLC_SETL;
                    cnt_next = SW'(EDGE_SETL_CYC);
                end else if (fifo_valid) begin
                    state_next = DBLC_LOAD;
                    cnt_next = SW'(DBLC_STROBE_LOW_CYC);
                end else if (upd_req_reg && mode_reg == DBLC_MODE_DOUBLE
                             && loaded_reg) begin
                    state_next = DBLC_GAP;
                    cnt_next = SW'(DBLC_DESKEW_CYC);
                end
            end
            DBLC_LOAD: begin
                if (cnt_reg == SW'(DBLC_CNT_ONE)) begin
                    state_next = DBLC_HOLD;
                    cnt_next = SW'(DBLC_DATA_HOLD_CYC);
                end
            end
            DBLC_HOLD: begin
                if (cnt_reg == SW'(DBLC_CNT_ONE)) begin
                    if (mode_reg == DBLC_MODE_EDGE) begin
                        state_next = DBLC_SETL;
                        cnt_next = SW'(EDGE_SETL_CYC);
                    end else if (upd_pend_reg) begin
                        state_next = DBLC_GAP;
                        cnt_next = SW'(DBLC_DESKEW_CYC);
                    end else begin
                        state_next = DBLC_IDLE;
                        cnt_next = SW'(DBLC_CNT_ZERO);
                    end
                end
            end
            DBLC_GAP: begin
                if (cnt_reg == SW'(DBLC_CNT_ONE)) begin
                    state_next = DBLC_UPD;
                    cnt_next = SW'(DBLC_STROBE_HIGH_CYC);
                end
            end
            DBLC_UPD: begin
                if (cnt_reg == SW'(DBLC_CNT_ONE)) begin
                    state_next = DBLC_SETL;
                    cnt_next = SW'(SETTLE_CYC);
                end
            end
            DBLC_SETL: begin
                if (cnt_reg == SW'(DBLC_CNT_ONE)) begin
                    state_next = DBLC_IDLE;
                end
            end
            default: begin
                state_next = DBLC_IDLE;
                cnt_next = SW'(DBLC_CNT_ZERO);
            end
        endcase
    end

    // state and counter
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= DBLC_IDLE;
            cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // mode is sampled only between transfers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_reg <= DBLC_MODE_DOUBLE;
            upd_pend_reg <= 1'b0;
        end else if (state_reg == DBLC_IDLE) begin
            mode_reg <= mode_sync_reg;
            upd_pend_reg <= fifo_valid && req.update;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data bus: new word presented on pop, held through data hold
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            data_reg <= '0;
        end else if (fifo_pop) begin
            data_reg <= dblc_code(req.word, req.twos_comp);
        end
    end

    // load strobe low for the stretched time, rising before data moves
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            load_n_reg <= 1'b1; // idle high, never floating
        end else begin
            load_n_reg <= !(state_next == DBLC_LOAD
                            && mode_reg == DBLC_MODE_DOUBLE);
        end
    end

    // select: low during load; in edge mode select and update are one
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            select_n_reg <= 1'b1;
            update_reg <= 1'b0;
        end else if (state_next == DBLC_IDLE && state_reg == DBLC_IDLE
                     && !fifo_valid) begin
            select_n_reg <= 1'b1;
            update_reg <= (mode_reg == DBLC_MODE_EDGE);
        end else if (mode_reg == DBLC_MODE_EDGE) begin
            // joined pair low while data is set up, rising edge applies
            select_n_reg <= !(state_next == DBLC_LOAD);
            update_reg <= !(state_next == DBLC_LOAD);
        end else begin
            select_n_reg <= !(state_next == DBLC_LOAD);
            update_reg <= (state_next == DBLC_UPD);
        end
    end

    // first-rank word written at least once since reset
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            loaded_reg <= 1'b0; // device ranks unknown till then
        end else if (state_reg == DBLC_HOLD) begin
            loaded_reg <= 1'b1;
        end
    end

    // registered source ready from the mirrored occupancy
    // looks one push ahead, so a full buffer never takes a word
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= (occ_next != OW'(FIFO_DEPTH));
        end
    end

    // busy flag from the next state, so the pin comes from a flop
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_next != DBLC_IDLE);
        end
    end

    assign DATA_O = data_reg; // word toward the core, bit 15 top
    assign SELECT_N_O = select_n_reg;
    assign LOAD_N_O = load_n_reg;
    assign UPDATE_O = update_reg;
    assign LOADED_O = loaded_reg;
    assign BUSY_O = busy_reg;
    assign SAMPLE_READY_O = ready_reg;

endmodule

// >>> sim/dblc_dev.sv
// model of the two-rank latch device on the far side of the host
// assumes pins come straight from the host driver; no clock, no reset
`timescale 1ns/10ps
module dblc_dev (
    input wire logic [15:0] data_i,
    input wire logic select_n_i,
    input wire logic load_n_i,
    input wire logic update_i,
    output logic [15:0] code_o
);
    ////////////////////////////////////////////////////////////
    // both ranks power up unknown
    logic [15:0] rank1_reg;
    // first rank open while select and load both low
    always_latch begin
        if (!select_n_i && !load_n_i) begin
            rank1_reg <= data_i;
        end
    end
    // second rank follows while update high, on its own
    // joined select and update give edge action
    // straight or offset binary code to the core
    always_latch begin
        if (update_i) begin
            code_o <= rank1_reg;
        end
    end
endmodule

// >>> sim/dblc_host_chk.sv
// assertions on the pins that the host drives toward the latch device
// assumes binding onto dblc_host, one clock, reset async active high
`timescale 1ns/10ps
module dblc_host_chk
    import dblc_pkg::*;
#(
    parameter int DATA_W = DBLC_DATA_W
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [DATA_W-1:0] DATA_O,
    input wire logic SELECT_N_O,
    input wire logic LOAD_N_O,
    input wire logic UPDATE_O,
    input wire logic BUSY_O
);
    logic [7:0] sel_cnt_reg;
    logic [7:0] upd_cnt_reg;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff RST_I;
    ////////////////////////////////////////////////////////////
    // cycles the select has been low, saturating
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I || SELECT_N_O) begin
            sel_cnt_reg <= 8'h00;
        end else if (sel_cnt_reg != 8'hFF) begin
            sel_cnt_reg <= sel_cnt_reg + 8'h01;
        end
    end
    // cycles the update has been high, saturating
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I || !UPDATE_O) begin
            upd_cnt_reg <= 8'h00;
        end else if (upd_cnt_reg != 8'hFF) begin
            upd_cnt_reg <= upd_cnt_reg + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////
    sel_with_load_a:
        assert property ($fell(LOAD_N_O) |-> $fell(SELECT_N_O))
        else $error("load strobe fell without select");
    data_steady_a:
        assert property (!SELECT_N_O && !$past(SELECT_N_O)
            |-> $stable(DATA_O))
        else $error("data moved while selected");
    data_hold_a:
        assert property ($rose(SELECT_N_O) |=> $stable(DATA_O) [*2])
        else $error("data hold after strobe too short");
    gap_kept_a:
        assert property ($rose(UPDATE_O) |-> $past(LOAD_N_O, 13))
        else $error("update too soon after load");
    low_time_a:
        assert property ($rose(SELECT_N_O)
            |-> sel_cnt_reg == DBLC_STROBE_LOW_CYC)
        else $error("strobe low time wrong");
    upd_width_a:
        assert property ($fell(UPDATE_O) |-> upd_cnt_reg >= 8'h0A)
        else $error("update pulse too short");
    upd_unsel_a:
        assert property ($rose(UPDATE_O) |-> SELECT_N_O)
        else $error("update rose while selected");
    sel_busy_a:
        assert property (!SELECT_N_O |-> BUSY_O)
        else $error("selected while not busy");
endmodule
bind dblc_host dblc_host_chk #(.DATA_W(DATA_W)) u_chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .DATA_O(DATA_O),
    .SELECT_N_O(SELECT_N_O), .LOAD_N_O(LOAD_N_O),
    .UPDATE_O(UPDATE_O), .BUSY_O(BUSY_O));

// >>> sim/dblc_host_tb.sv
// self-checking bench: host driver feeding the latch device model
// assumes dblc_dev as the far side and the bound pin checker
`timescale 1ns/10ps
module dblc_host_tb;
    import dblc_pkg::*;
    logic CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic [15:0] SAMPLE_I = 16'h0000;
    logic SAMPLE_TWOS_I = 1'b0;
    logic SAMPLE_UPDATE_I = 1'b0;
    logic SAMPLE_VALID_I = 1'b0;
    logic EDGE_MODE_I = 1'b0;
    logic UPDATE_ALL_I = 1'b0;
    logic SAMPLE_READY_O, SELECT_N_O, LOAD_N_O, UPDATE_O, BUSY_O, LOADED_O;
    logic [15:0] DATA_O, code, last_w, applied;
    logic [16:0] ent;
    logic [16:0] exp_q[$];
    logic [31:0] rng = 32'h00013F3F;
    logic have_app = 1'b0, edge_m = 1'b0, saw_full = 1'b0;
    logic sel_q = 1'b1, upd_q = 1'b0;
    logic [15:0] corner[6] = '{16'h0000, 16'hFFFF, 16'h8000,
        16'h0000, 16'h7FFF, 16'h8000};
    int fails = 0, n_compared = 0, cycles = 0;
    ////////////////////////////////////////////////////////////
    always #4 CLK_I = ~CLK_I;
    dblc_host #(.SETTLE_CYC(4)) u_dut (
        .CLK_I(CLK_I), .RST_I(RST_I), .SAMPLE_I(SAMPLE_I),
        .SAMPLE_TWOS_I(SAMPLE_TWOS_I), .SAMPLE_UPDATE_I(SAMPLE_UPDATE_I),
        .SAMPLE_VALID_I(SAMPLE_VALID_I), .SAMPLE_READY_O(SAMPLE_READY_O),
        .EDGE_MODE_I(EDGE_MODE_I), .UPDATE_ALL_I(UPDATE_ALL_I),
        .DATA_O(DATA_O), .SELECT_N_O(SELECT_N_O), .LOAD_N_O(LOAD_N_O),
        .UPDATE_O(UPDATE_O), .BUSY_O(BUSY_O), .LOADED_O(LOADED_O));
    // edge wiring: load pin grounded, update joined to select
    dblc_dev u_dev (.data_i(DATA_O), .select_n_i(SELECT_N_O),
        .load_n_i(edge_m ? 1'b0 : LOAD_N_O),
        .update_i(edge_m ? SELECT_N_O : UPDATE_O), .code_o(code));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    // word as the pins should carry it
    function automatic logic [15:0] pin_word(input logic [15:0] w,
        input logic tc);
        return tc ? (w ^ 16'h8000) : w;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic conclude();
        if (fails == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // offer one sample and hold it until taken
    task automatic send(input logic [15:0] w, input logic tc, input logic u);
        SAMPLE_I <= w;
        SAMPLE_TWOS_I <= tc;
        SAMPLE_UPDATE_I <= u;
        SAMPLE_VALID_I <= 1'b1;
        do @(negedge CLK_I); while (SAMPLE_READY_O !== 1'b1);
        @(posedge CLK_I);
        exp_q.push_back({pin_word(w, tc), u});
    endtask
    task automatic rnd(input int n, input logic ua);
        for (int i = 0; i < n; i++) begin
            rng = xs(rng);
            send(rng[15:0], rng[16], rng[17] & ua);
        end
    endtask
    task automatic settle();
        SAMPLE_VALID_I <= 1'b0;
        do @(negedge CLK_I); while (exp_q.size() != 0 || BUSY_O !== 1'b0);
        @(posedge CLK_I);
    endtask
    ////////////////////////////////////////////////////////////
    // cycle ceiling against hangs
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            $display("CHECK FAILED at %0t: run too long", $time);
            conclude();
        end
    end
    // pin scoreboard, sampled at the falling edge once pins settled
    always @(negedge CLK_I) begin
        if (!RST_I) begin
            if (SAMPLE_VALID_I && !SAMPLE_READY_O) saw_full = 1'b1;
            if (edge_m) chk({15'h0000, LOAD_N_O}, 16'h0001);
            if (SELECT_N_O && !sel_q) begin
                ent = exp_q.pop_front();
                last_w = ent[16:1];
                chk(u_dev.rank1_reg, last_w);
                if (edge_m) begin
                    chk(code, last_w);
                    applied = last_w;
                    have_app = 1'b1;
                end else if (!ent[0] && have_app) begin
                    chk(code, applied);
                end
            end
            if (!UPDATE_O && upd_q && !edge_m) begin
                applied = last_w;
                have_app = 1'b1;
                chk(code, applied);
            end
            sel_q = SELECT_N_O;
            upd_q = UPDATE_O;
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge CLK_I);
        RST_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        chk({15'h0000, LOADED_O}, 16'h0000);
        // code corners, plain then twos complement
        for (int i = 0; i < 6; i++) send(corner[i], i >= 3, 1'b1);
        settle();
        chk({15'h0000, LOADED_O}, 16'h0001);
        // burst past the fifo depth, updates mixed
        rnd(14, 1'b1);
        settle();
        chk({15'h0000, saw_full}, 16'h0001);
        // words parked in the first rank, then a broadcast update
        rnd(3, 1'b0);
        settle();
        UPDATE_ALL_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        UPDATE_ALL_I <= 1'b0;
        repeat (30) @(posedge CLK_I);
        chk(code, last_w);
        // joined select and update wiring
        EDGE_MODE_I <= 1'b1;
        edge_m = 1'b1;
        repeat (4) @(posedge CLK_I);
        rnd(8, 1'b1);
        settle();
        EDGE_MODE_I <= 1'b0;
        repeat (4) @(posedge CLK_I);
        edge_m = 1'b0;
        rnd(10, 1'b1);
        settle();
        conclude();
    end
endmodule
